/* File: cgir_params.svh */
// Function
// - Rate register at 04, alias 0A, resets 08.
// - Rate code doubles frequency, 0.0625 to 16 Hz.
// - One-shot write in standby starts one conversion.
// - Read-only maker code at FE.
// - Read-only revision code at FF.
// - Input register at 1A mirrors five pins.
// - Bits 7 to 5 of both read zero.
// - Output register at 1B follows input bits.
// - Input register captures pins at power-on.
// - Output register loads strap pins at power-on.
// - Busy flag high while a conversion runs.
`ifndef CGIR_PARAMS_SVH
`define CGIR_PARAMS_SVH
// ==========================================================
// Register offsets.
`define CGIR_OFS_RATE 8'h04
`define CGIR_OFS_RATE_ALIAS 8'h0a
`define CGIR_OFS_ONESHOT 8'h0f
`define CGIR_OFS_GEN_IN 8'h1a
`define CGIR_OFS_GPO 8'h1b
`define CGIR_OFS_MAKER 8'hfe
`define CGIR_OFS_REV 8'hff
// ==========================================================
// Reset values and field layout.
`define CGIR_RATE_RST 8'h08
`define CGIR_RATE_MAX 8'h08
`define CGIR_READ_ZERO 8'h00
`define CGIR_GP_UNUSED 3'h0
`define CGIR_GP_W 5
// ==========================================================
// Timing: the fastest period is 62.5 ms at code 08.
`define CGIR_CLK_NS 8
`define CGIR_FAST_PERIOD_NS 62500000
`define CGIR_FAST_PERIOD_CYC (`CGIR_FAST_PERIOD_NS / `CGIR_CLK_NS)
`endif

/* File: cgir_pkg.sv */
`default_nettype none
package cgir_pkg;
   // Register access request as delivered by the serial engine.
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } cgir_req_s;
   // Read answer.
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } cgir_rsp_s;
   // Conversion sequencer states.
   typedef enum logic [1:0] {
      CGIR_IDLE = 2'b01,
      CGIR_BUSY = 2'b10
   } cgir_seq_e;
endpackage
`default_nettype wire

/* File: cgir_rate_timer.sv */
`timescale 1ns/1ns
`default_nettype none
`include "cgir_params.svh"
module cgir_rate_timer #(
   parameter int unsigned FAST_PERIOD = `CGIR_FAST_PERIOD_CYC
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic run,
   input wire logic [7:0] rate,
   output logic tick
);
   import cgir_pkg::*;
   logic [31:0] count;
   logic [31:0] next_count;

   // Period in cycles: codes above the top code run at 16 Hz.
   function automatic logic [31:0] period(input logic [7:0] code);
      logic [7:0] c;
      c = (code > `CGIR_RATE_MAX) ? `CGIR_RATE_MAX : code;
      period = 32'(FAST_PERIOD) << (`CGIR_RATE_MAX - c);
   endfunction

   // ==========================================================
   // Countdown; held at reload value while stopped.
   always_comb begin
      tick = run && (count == 32'h0);
      if (!run || tick) begin
         next_count = period(rate) - 32'h1;
      end else begin
         next_count = count - 32'h1;
      end
   end

   // Counter register.
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         count <= 32'h0;
      end else begin
         count <= next_count;
      end
   end

   // No periodic start may leak out while the timer is stopped.
   chk_tick_idle: assert property (
      @(posedge mclk) disable iff (sys_rst)
      !run |-> !tick)
      else $error("rate tick while stopped");
endmodule
`default_nettype wire

/* File: cgir_conv_seq.sv */
`timescale 1ns/1ns
`default_nettype none
`include "cgir_params.svh"
module cgir_conv_seq (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic start,
   input wire logic conv_done,
   output logic conv_start,
   output logic busy
);
   import cgir_pkg::*;
   cgir_seq_e state;
   cgir_seq_e next_state;

   // ==========================================================
   // A start is taken only when idle; busy lasts until done.
   always_comb begin
      conv_start = 1'b0;
      next_state = state;
      case (state)
         CGIR_IDLE: begin
            if (start) begin
               conv_start = 1'b1;
               next_state = CGIR_BUSY;
            end
         end
         CGIR_BUSY: begin
            if (conv_done) begin
               next_state = CGIR_IDLE;
            end
         end
         default: next_state = CGIR_IDLE;
      endcase
   end

   // State register.
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= CGIR_IDLE;
      end else begin
         state <= next_state;
      end
   end

   assign busy = (state == CGIR_BUSY);

   // Busy rises only after a start and falls right after done.
   chk_busy_cause: assert property (
      @(posedge mclk) disable iff (sys_rst)
      $rose(busy) |-> $past(conv_start))
      else $error("busy without start");
   chk_busy_end: assert property (
      @(posedge mclk) disable iff (sys_rst)
      busy && conv_done |=> !busy)
      else $error("busy past done");
endmodule
`default_nettype wire

/* File: cgir_regs.sv */
`timescale 1ns/1ns
`default_nettype none
`include "cgir_params.svh"
module cgir_regs #(
   parameter int unsigned FAST_PERIOD = `CGIR_FAST_PERIOD_CYC,
   // Identification codes; the values are arbitrary.
   parameter logic [7:0] MAKER_ID = 8'h5a,
   parameter logic [7:0] REV_ID = 8'h3c
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire cgir_pkg::cgir_req_s req,
   output var cgir_pkg::cgir_rsp_s rsp,
   input wire logic standby,
   input wire logic conv_done,
   output logic conv_start,
   output logic busy,
   input wire logic [4:0] general_pin,
   input wire logic [4:0] default_strap_pin,
   output logic [4:0] general_pin_output
);
   import cgir_pkg::*;

   // ==========================================================
   // Address decode helpers.
   function automatic logic is_rate(input logic [7:0] a);
      is_rate = (a == `CGIR_OFS_RATE) || (a == `CGIR_OFS_RATE_ALIAS);
   endfunction

   function automatic logic [7:0] gp_word(input logic [4:0] b);
      gp_word = {`CGIR_GP_UNUSED, b};
   endfunction

   logic [7:0] conv_rate;
   logic [7:0] next_conv_rate;
   logic oneshot_pend;
   logic next_oneshot_pend;
   logic [4:0] general_input_bits;
   logic [4:0] next_general_input_bits;
   logic [4:0] gpo;
   logic [4:0] next_gpo;
   logic gp_loaded;
   logic next_gp_loaded;
   cgir_rsp_s next_rsp;
   logic rate_tick;
   logic start_req;
   logic wr_rate;
   logic wr_oneshot;
   logic wr_gpo;

   assign wr_rate = req.wr && is_rate(req.addr);
   assign wr_oneshot = req.wr && (req.addr == `CGIR_OFS_ONESHOT);
   assign wr_gpo = req.wr && (req.addr == `CGIR_OFS_GPO);

   // ==========================================================
   // Conversion rate register.
   always_comb begin
      next_conv_rate = conv_rate;
      if (wr_rate) begin
         next_conv_rate = req.wdata;
      end
   end

   // Rate register flop.
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         conv_rate <= `CGIR_RATE_RST;
      end else begin
         conv_rate <= next_conv_rate;
      end
   end

   // Rate register holds its reset code and takes writes at both offsets.
   chk_rate_reset: assert property (
      @(posedge mclk) $fell(sys_rst) |-> conv_rate == `CGIR_RATE_RST)
      else $error("rate reset value wrong");
   chk_rate_alias: assert property (
      @(posedge mclk) disable iff (sys_rst)
      wr_rate |=> conv_rate == $past(req.wdata))
      else $error("rate write lost");

   // ==========================================================
   // One-shot request: only taken in standby, held until accepted.
   always_comb begin
      next_oneshot_pend = oneshot_pend;
      if (oneshot_pend && !busy) begin
         next_oneshot_pend = 1'b0;
      end
      if (wr_oneshot && standby) begin
         next_oneshot_pend = 1'b1;
      end
   end

   // One-shot flop.
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         oneshot_pend <= 1'b0;
      end else begin
         oneshot_pend <= next_oneshot_pend;
      end
   end

   // A one-shot in standby starts exactly one conversion; outside
   // standby it leaves no trace, and standby alone starts nothing.
   sequence s_oneshot_req;
      wr_oneshot && standby && !busy && !oneshot_pend;
   endsequence

   sequence s_start_soon;
      ##1 conv_start ##1 busy;
   endsequence

   chk_oneshot_run: assert property (
      @(posedge mclk) disable iff (sys_rst)
      s_oneshot_req |-> s_start_soon)
      else $error("one-shot did not start a conversion");
   chk_oneshot_fire: assert property (
      @(posedge mclk) disable iff (sys_rst)
      oneshot_pend && !busy |-> conv_start)
      else $error("pending one-shot not started");
   chk_standby_quiet: assert property (
      @(posedge mclk) disable iff (sys_rst)
      standby && !oneshot_pend |-> !conv_start)
      else $error("conversion started in standby unasked");
   chk_oneshot_ignore: assert property (
      @(posedge mclk) disable iff (sys_rst)
      wr_oneshot && !standby && !oneshot_pend |=> !oneshot_pend)
      else $error("one-shot taken outside standby");

   // Periodic conversions run only outside standby.
   cgir_rate_timer #(
      .FAST_PERIOD(FAST_PERIOD)
   ) i_cgir_rate_timer (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .run(!standby),
      .rate(conv_rate),
      .tick(rate_tick)
   );

   assign start_req = rate_tick || oneshot_pend;

   // Conversion sequencer driving the busy flag.
   cgir_conv_seq i_cgir_conv_seq (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .start(start_req),
      .conv_done(conv_done),
      .conv_start(conv_start),
      .busy(busy)
   );

   // ==========================================================
   // General purpose registers. The first edge after reset
   // release captures pins and straps; afterwards the input
   // register tracks the pins and the output register follows
   // each change of the input bits unless the host writes it.
   always_comb begin
      next_gp_loaded = 1'b1;
      next_general_input_bits = general_pin;
      next_gpo = gpo;
      if (!gp_loaded) begin
         next_gpo = default_strap_pin;
      end else if (wr_gpo) begin
         next_gpo = req.wdata[4:0];
      end else if (general_pin != general_input_bits) begin
         next_gpo = general_pin;
      end
   end

   // General purpose flops.
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         gp_loaded <= 1'b0;
         general_input_bits <= 5'h00;
         gpo <= 5'h00;
      end else begin
         gp_loaded <= next_gp_loaded;
         general_input_bits <= next_general_input_bits;
         gpo <= next_gpo;
      end
   end

   // Pins and straps land at the first edge after reset; then the
   // input register tracks the pins and the output register follows.
   chk_input_capture: assert property (
      @(posedge mclk) disable iff (sys_rst)
      !gp_loaded |=> general_input_bits == $past(general_pin))
      else $error("input not captured at power-on");
   chk_gpo_strap: assert property (
      @(posedge mclk) disable iff (sys_rst)
      !gp_loaded |=> gpo == $past(default_strap_pin))
      else $error("strap value not loaded");
   chk_input_track: assert property (
      @(posedge mclk) disable iff (sys_rst)
      gp_loaded |=> general_input_bits == $past(general_pin))
      else $error("input register lost a pin level");
   chk_gpo_follow: assert property (
      @(posedge mclk) disable iff (sys_rst)
      gp_loaded && !wr_gpo && general_pin != general_input_bits
      |=> gpo == $past(general_pin))
      else $error("output register did not follow");

   assign general_pin_output = gpo;

   // ==========================================================
   // Read mux; unmapped and write-only offsets read zero.
   always_comb begin
      next_rsp.valid = req.rd;
      next_rsp.data = `CGIR_READ_ZERO;
      if (req.rd) begin
         if (is_rate(req.addr)) begin
            next_rsp.data = conv_rate;
         end else begin
            case (req.addr)
               `CGIR_OFS_GEN_IN: begin
                  next_rsp.data = gp_word(general_input_bits);
               end
               `CGIR_OFS_GPO: next_rsp.data = gp_word(gpo);
               `CGIR_OFS_MAKER: next_rsp.data = MAKER_ID;
               `CGIR_OFS_REV: next_rsp.data = REV_ID;
               default: next_rsp.data = `CGIR_READ_ZERO;
            endcase
         end
      end
   end

   // Answer register.
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         rsp <= '0;
      end else begin
         rsp <= next_rsp;
      end
   end

   // ==========================================================
   // Read answers stand one cycle after the read strobe.
   chk_rate_read: assert property (
      @(posedge mclk) disable iff (sys_rst)
      req.rd && is_rate(req.addr) |=> rsp.data == $past(conv_rate))
      else $error("rate read wrong");
   chk_maker_read: assert property (
      @(posedge mclk) disable iff (sys_rst)
      req.rd && req.addr == `CGIR_OFS_MAKER |=> rsp.data == MAKER_ID)
      else $error("maker code wrong");
   chk_rev_read: assert property (
      @(posedge mclk) disable iff (sys_rst)
      req.rd && req.addr == `CGIR_OFS_REV |=> rsp.data == REV_ID)
      else $error("revision code wrong");
   chk_input_read: assert property (
      @(posedge mclk) disable iff (sys_rst)
      req.rd && req.addr == `CGIR_OFS_GEN_IN
      |=> rsp.data == gp_word($past(general_input_bits)))
      else $error("input register read wrong");
   chk_gp_unused: assert property (
      @(posedge mclk) disable iff (sys_rst)
      req.rd && (req.addr == `CGIR_OFS_GEN_IN || req.addr == `CGIR_OFS_GPO)
      |=> rsp.data[7:5] == `CGIR_GP_UNUSED)
      else $error("unused bits not zero");
   chk_oneshot_read: assert property (
      @(posedge mclk) disable iff (sys_rst)
      req.rd && req.addr == `CGIR_OFS_ONESHOT
      |=> rsp.data == `CGIR_READ_ZERO)
      else $error("one-shot register did not read zero");
endmodule
`default_nettype wire

/* File: cgir_conv_model.sv */
`timescale 1ns/1ns
`default_nettype none
module cgir_conv_model #(
   parameter int DLY = 1
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic conv_start,
   output logic conv_done
);
   int cnt;
   // A started conversion ends with a one-cycle done pulse DLY cycles on.
   always @(negedge mclk or posedge sys_rst) begin
      conv_done <= 1'b0;
      if (sys_rst) begin
         cnt <= 0;
      end else if (conv_start) begin
         cnt <= DLY;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
         conv_done <= (cnt == 1);
      end
   end
endmodule
`default_nettype wire

/* File: conv_rate_gpio_id_regs_bench.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin \
   comparisons++; \
   if ((g) !== (e)) begin \
      errors++; \
      $display("MISMATCH %s exp %h got %h", nm, e, g); \
   end \
end
module conv_rate_gpio_id_regs_bench;
   import cgir_pkg::*;
   localparam int FP = 8;
   localparam int CD = 2;
   logic mclk = 0, sys_rst = 1, standby = 1;
   logic conv_done, conv_start, busy;
   cgir_req_s req = '0;
   cgir_rsp_s rsp;
   logic [4:0] gpin = 5'h15, strap = 5'h0a, gpout;
   int errors = 0, comparisons = 0;
   // ==========================================================
   // Clock, design and converter model.
   always #4 mclk = ~mclk;
   cgir_regs #(.FAST_PERIOD(FP)) i_cgir_regs (.mclk(mclk),
      .sys_rst(sys_rst), .req(req), .rsp(rsp), .standby(standby),
      .conv_done(conv_done), .conv_start(conv_start), .busy(busy),
      .general_pin(gpin), .default_strap_pin(strap),
      .general_pin_output(gpout));
   cgir_conv_model #(.DLY(CD)) i_cgir_conv_model (.mclk(mclk),
      .sys_rst(sys_rst), .conv_start(conv_start),
      .conv_done(conv_done));
   // ==========================================================
   // Closing report.
   task automatic report_and_stop;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Register write and checked read, one strobe cycle each.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      req.wr = 1'b1;
      req.addr = a;
      req.wdata = d;
      @(negedge mclk);
      req.wr = 1'b0;
   endtask
   task automatic rchk(input string nm, input logic [7:0] a,
                       input logic [7:0] e);
      @(negedge mclk);
      req.rd = 1'b1;
      req.addr = a;
      @(negedge mclk);
      req.rd = 1'b0;
      `CHK("read valid", 1'b1, rsp.valid)
      `CHK(nm, e, rsp.data)
   endtask
   // Cycles until the next conversion start, bounded.
   task automatic wait_start(output int n);
      n = 0;
      do begin
         @(negedge mclk);
         n++;
      end while (conv_start !== 1'b1 && n < 5000);
      if (n >= 5000) begin
         errors++;
         report_and_stop();
      end
   endtask
   // Counts starts and busy cycles over a window of cycles.
   task automatic count_starts(input int len, output int s, output int b);
      s = 0;
      b = 0;
      repeat (len) begin
         @(negedge mclk);
         s += (conv_start === 1'b1);
         b += (busy === 1'b1);
      end
   endtask
   // ==========================================================
   // Scenarios.
   task automatic t_reset;
      rchk("rate", 8'h04, 8'h08);
      rchk("rate alias", 8'h0a, 8'h08);
      rchk("input reg", 8'h1a, 8'h15);
      rchk("output reg", 8'h1b, 8'h0a);
      `CHK("output pins", 5'h0a, gpout)
      rchk("one-shot", 8'h0f, 8'h00);
   endtask
   task automatic t_readonly;
      wr(8'hfe, 8'h00);
      wr(8'hff, 8'h00);
      wr(8'h1a, 8'h00);
      rchk("maker", 8'hfe, 8'h5a);
      rchk("revision", 8'hff, 8'h3c);
      rchk("input reg", 8'h1a, 8'h15);
   endtask
   task automatic t_gp;
      @(negedge mclk);
      gpin = 5'h1f;
      repeat (2) @(negedge mclk);
      rchk("input reg", 8'h1a, 8'h1f);
      rchk("output reg", 8'h1b, 8'h1f);
      @(negedge mclk);
      gpin = 5'h03;
      repeat (2) @(negedge mclk);
      rchk("input reg", 8'h1a, 8'h03);
      `CHK("output pins", 5'h03, gpout)
      wr(8'h1b, 8'hf4);
      rchk("output reg", 8'h1b, 8'h14);
   endtask
   task automatic t_oneshot;
      int s, b, s0;
      wr(8'h0a, 8'h07);
      rchk("rate", 8'h04, 8'h07);
      count_starts(20, s, b);
      `CHK("standby starts", 0, s)
      wr(8'h0f, 8'ha5);
      s0 = (conv_start === 1'b1);
      count_starts(30, s, b);
      `CHK("one-shot starts", 1, s0 + s)
      `CHK("busy cycles", CD, b)
      `CHK("busy after", 1'b0, busy)
   endtask
   task automatic t_rate;
      int n, s, b;
      standby = 1'b0;
      for (int c = 0; c <= 8; c++) begin
         wr(8'h04, 8'(c));
         wait_start(n);
         wait_start(n);
         wait_start(n);
         `CHK("period", FP << (8 - c), n)
      end
      wr(8'h04, 8'h00);
      wait_start(n);
      wait_start(n);
      wr(8'h0f, 8'h01);
      count_starts(200, s, b);
      `CHK("ignored one-shot", 0, s)
   endtask
   // ==========================================================
   // Main sequence.
   initial begin
      repeat (12) @(negedge mclk);
      sys_rst = 1'b0;
      @(negedge mclk);
      t_reset();
      t_readonly();
      t_gp();
      t_oneshot();
      t_rate();
      report_and_stop();
   end
endmodule
`default_nettype wire
